// ===== rct_carrier.sv
`timescale 1ns/1ps
module rct_carrier (
	input wire logic mclk,
	input wire logic srst,
	input wire logic active,
	input wire logic [8:0] low_width,
	input wire logic [8:0] high_width,
	output logic level
);
	import rct_pkg::*;

	rct_car_e state_q, state_d;
	logic [8:0] cnt_q, cnt_d;
	logic level_q;

	assign level = level_q;

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
		RCT_CAR_IDLE:
			if (active)
			begin
				state_d = RCT_CAR_LOW;
				cnt_d = low_width;
			end
		RCT_CAR_LOW:
			if (!active)
				state_d = RCT_CAR_IDLE;
			else if (cnt_q == 9'h000)
			begin
				state_d = RCT_CAR_HIGH;
				cnt_d = high_width;
			end
			else
				cnt_d = cnt_q - 9'h001;
		RCT_CAR_HIGH:
			// a high phase runs out unless srst cuts it, even once the gate has dropped
			if (cnt_q != 9'h000)
				cnt_d = cnt_q - 9'h001;
			else if (active)
			begin
				state_d = RCT_CAR_LOW;
				cnt_d = low_width;
			end
			else
				state_d = RCT_CAR_IDLE;
		default:
			state_d = RCT_CAR_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_q <= RCT_CAR_IDLE;
			cnt_q <= RST_WIDTH;
			level_q <= RST_BIT;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			level_q <= (state_d == RCT_CAR_HIGH);
		end
	end

	property p_start_low;
		@(posedge mclk) disable iff (srst)
		state_q == RCT_CAR_IDLE && active |=> state_q == RCT_CAR_LOW && !level;
	endproperty
	a_start_low: assert property (p_start_low) else $error("carrier did not start low");

	property p_phase_len;
		@(posedge mclk) disable iff (srst)
		state_q == RCT_CAR_LOW && state_d == RCT_CAR_HIGH |=> cnt_q == $past(high_width) && level;
	endproperty
	a_phase_len: assert property (p_phase_len) else $error("high phase not loaded with width");

	property p_finish_high;
		@(posedge mclk) disable iff (srst)
		state_q == RCT_CAR_HIGH && cnt_q != 9'h000 |=> state_q == RCT_CAR_HIGH && level;
	endproperty
	a_finish_high: assert property (p_finish_high) else $error("high phase cut short");
endmodule

// ===== rct_emitter.sv
`timescale 1ns/1ps
// stands in for the emitter stage: keeps the lengths of the last finished high and low runs on the pin
module rct_emitter (
	input wire logic mclk,
	input wire logic drive,
	output logic [15:0] high_len,
	output logic [15:0] low_len
);
	logic [15:0] run_q = 16'h0000;
	logic last_q = 1'b0;
	initial high_len = 16'h0000;
	initial low_len = 16'h0000;
	always @(posedge mclk)
	begin
		if (drive !== last_q)
		begin
			if (last_q)
				high_len <= run_q;
			else
				low_len <= run_q;
			run_q <= 16'h0001;
		end
		else
			run_q <= run_q + 16'h0001;
		last_q <= drive;
	end
endmodule

// ===== rct_pkg.sv
package rct_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte addresses, one aligned word each
	localparam logic [7:0] OFS_PRESET_LO = 8'h00;
	localparam logic [7:0] OFS_PRESET_HI = 8'h04;
	localparam logic [7:0] OFS_LOW_LO = 8'h08;
	localparam logic [7:0] OFS_LOW_HI = 8'h0c;
	localparam logic [7:0] OFS_HIGH_LO = 8'h10;
	localparam logic [7:0] OFS_HIGH_HI = 8'h14;

	// field positions inside the upper bytes
	localparam int BIT_TOP = 0;
	localparam int BIT_RUN = 1;
	localparam int BIT_INHIBIT = 1;
	localparam int BIT_END = 7;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [8:0] RST_WIDTH = 9'h000;
	localparam logic RST_BIT = 1'b0;
	localparam logic RST_END = 1'b1;
	localparam logic RST_INHIBIT = 1'b1;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// timer step: one count per this many input clocks
	localparam int TICK_CYCLES = 64;
	localparam logic [5:0] PRESC_LAST = 6'(TICK_CYCLES - 1);

	typedef enum logic [1:0] {
		RCT_CAR_IDLE = 2'b00,
		RCT_CAR_LOW = 2'b01,
		RCT_CAR_HIGH = 2'b10
	} rct_car_e;
endpackage

// ===== rct_testbench.sv
`timescale 1ns/1ps
module testbench;
	import rct_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic e;} rct_row_s;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic pin;
	logic er;
	logic [15:0] hi;
	logic [15:0] lo;
	int n_mismatch = 0;
	int check_count = 0;
	rct_row_s rows [16] = '{
		'{1'b0, OFS_PRESET_LO, 8'h00, 8'h00, 1'b0}, '{1'b0, OFS_PRESET_HI, 8'h00, 8'h80, 1'b0},
		'{1'b0, OFS_LOW_LO, 8'h00, 8'h00, 1'b0}, '{1'b0, OFS_LOW_HI, 8'h00, 8'h00, 1'b0},
		'{1'b0, OFS_HIGH_LO, 8'h00, 8'h00, 1'b0}, '{1'b0, OFS_HIGH_HI, 8'h00, 8'h02, 1'b0},
		'{1'b1, OFS_PRESET_LO, 8'hff, 8'h00, 1'b0}, '{1'b0, OFS_PRESET_LO, 8'h00, 8'hff, 1'b0},
		'{1'b1, OFS_LOW_HI, 8'hff, 8'h00, 1'b0}, '{1'b0, OFS_LOW_HI, 8'h00, 8'h01, 1'b0},
		'{1'b1, OFS_HIGH_HI, 8'hff, 8'h00, 1'b0}, '{1'b0, OFS_HIGH_HI, 8'h00, 8'h03, 1'b0},
		'{1'b1, 8'h18, 8'h5a, 8'h00, 1'b1}, '{1'b0, 8'h18, 8'h00, 8'h00, 1'b1},
		'{1'b1, OFS_PRESET_HI, 8'h80, 8'h00, 1'b0}, '{1'b0, OFS_PRESET_HI, 8'h00, 8'h00, 1'b0}
	};

	rct_top dut_u (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .remote_output_pin(pin));
	rct_emitter emit_u (.mclk(mclk), .drive(pin), .high_len(hi), .low_len(lo));

	initial
	begin
		forever #10 mclk = ~mclk;
	end

	task chk(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x)
		begin
			n_mismatch++;
			$display("Error %0t: got %h want %h", $time, s, x);
		end
	endtask

	// the slave decides the wait; only the watchdog ends a hang here
	task rw(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task results();
		$display("mismatches %0d, checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		results();
	end

	initial
	begin
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		chk({31'h0, pin}, 32'h0000_0000);
		foreach (rows[i])
		begin
			rw(rows[i].w, rows[i].a, rows[i].d);
			chk(rd, {24'h00_0000, rows[i].x});
			chk({31'h0, er}, {31'h0, rows[i].e});
		end
		rw(1'b1, OFS_PRESET_LO, 8'h03);
		rw(1'b1, OFS_PRESET_HI, 8'h02);
		rw(1'b0, OFS_PRESET_HI, 8'h00);
		chk(rd, 32'h0000_0002);
		repeat (300) @(posedge mclk);
		chk({16'h0000, hi}, 32'h0000_0100);
		chk({31'h0, pin}, 32'h0000_0000);
		rw(1'b0, OFS_PRESET_HI, 8'h00);
		chk(rd, 32'h0000_0082);
		rw(1'b1, OFS_PRESET_LO, 8'h00);
		rw(1'b1, OFS_PRESET_HI, 8'h02);
		repeat (100) @(posedge mclk);
		chk({16'h0000, hi}, 32'h0000_0040);
		rw(1'b1, OFS_PRESET_LO, 8'h01);
		rw(1'b1, OFS_PRESET_HI, 8'h02);
		repeat (20) @(posedge mclk);
		rw(1'b1, OFS_PRESET_HI, 8'h00);
		repeat (4) @(posedge mclk);
		chk({31'h0, pin}, 32'h0000_0000);
		chk({31'h0, hi < 16'h0080}, 32'h0000_0001);
		rw(1'b0, OFS_PRESET_HI, 8'h00);
		chk(rd, 32'h0000_0000);
		rw(1'b1, OFS_PRESET_HI, 8'h02);
		repeat (150) @(posedge mclk);
		chk({16'h0000, hi}, 32'h0000_0080);
		// widths go in while the pin is low, before the timer starts
		rw(1'b1, OFS_LOW_LO, 8'h02);
		rw(1'b1, OFS_LOW_HI, 8'h00);
		rw(1'b1, OFS_HIGH_LO, 8'h06);
		rw(1'b1, OFS_HIGH_HI, 8'h00);
		rw(1'b1, OFS_PRESET_LO, 8'h03);
		rw(1'b1, OFS_PRESET_HI, 8'h02);
		repeat (5) @(posedge mclk);
		chk({31'h0, pin}, 32'h0000_0000);
		// period of 10 puts the gate closing in mid high phase
		repeat (300) @(posedge mclk);
		chk({16'h0000, hi}, 32'h0000_0007);
		chk({16'h0000, lo}, 32'h0000_0003);
		chk({31'h0, pin}, 32'h0000_0000);
		// reset again in mid-run, timed so the pin would still be high without it
		rw(1'b1, OFS_PRESET_HI, 8'h02);
		repeat (14) @(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		chk({31'h0, pin}, 32'h0000_0000);
		rw(1'b0, OFS_PRESET_HI, 8'h00);
		chk(rd, 32'h0000_0080);
		rw(1'b0, OFS_HIGH_HI, 8'h00);
		chk(rd, 32'h0000_0002);
		rw(1'b0, OFS_PRESET_LO, 8'h00);
		chk(rd, 32'h0000_0000);
		results();
	end
endmodule

// ===== rct_top.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module rct_top (
	input wire logic mclk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rct_pkg::ADDR_W-1:0] paddr,
	input wire logic [rct_pkg::DATA_W-1:0] pwdata,
	output logic [rct_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic remote_output_pin
);
	import rct_pkg::*;

	logic [7:0] preset_low_q, preset_low_d;
	logic top_bit_q, top_bit_d;
	logic run_en_q, run_en_d;
	logic end_flag_q, end_flag_d;
	logic [8:0] cnt_q, cnt_d;
	logic [5:0] presc_q, presc_d;
	logic [8:0] low_w_q, low_w_d;
	logic [8:0] high_w_q, high_w_d;
	logic inhibit_q, inhibit_d;
	logic pin_q, pin_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic setup;
	logic wr_en;
	logic wr_hi;
	logic mapped;
	logic running;
	logic tick;
	logic car_level;
	logic [7:0] rd_byte;
	logic [7:0] wbyte;

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign remote_output_pin = pin_q;

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & pready_q & ~pslverr_q;
	assign wr_hi = wr_en && (paddr == OFS_PRESET_HI);
	assign wbyte = pwdata[7:0];
	// the run bit stays high after the end; the end flag is what stops the timer
	assign running = run_en_q & ~end_flag_q;
	assign tick = running && (presc_q == PRESC_LAST);

	// read view of every register
	always_comb
	begin
		mapped = 1'b1;
		rd_byte = RST_BYTE;
		case (paddr)
		OFS_PRESET_LO:
			rd_byte = preset_low_q;
		OFS_PRESET_HI:
			rd_byte = {end_flag_q, 5'h00, run_en_q, top_bit_q};
		OFS_LOW_LO:
			rd_byte = low_w_q[7:0];
		OFS_LOW_HI:
			rd_byte = {7'h00, low_w_q[8]};
		OFS_HIGH_LO:
			rd_byte = high_w_q[7:0];
		OFS_HIGH_HI:
			rd_byte = {6'h00, inhibit_q, high_w_q[8]};
		default:
			mapped = 1'b0;
		endcase
	end

	// read data and the answer are captured in the setup cycle so that
	// every bus output leaves a flip-flop; one access cycle per transfer
	always_comb
	begin
		pready_d = setup;
		pslverr_d = setup & ~mapped;
		prdata_d = prdata_q;
		if (setup)
		begin
			if (mapped && !pwrite)
				prdata_d = {24'h00_0000, rd_byte};
			else
				prdata_d = RST_WORD;
		end
	end

	// plain storage registers
	always_comb
	begin
		preset_low_d = preset_low_q;
		low_w_d = low_w_q;
		high_w_d = high_w_q;
		inhibit_d = inhibit_q;
		if (wr_en)
		begin
			case (paddr)
			OFS_PRESET_LO:
				preset_low_d = wbyte;
			OFS_LOW_LO:
				low_w_d = {low_w_q[8], wbyte};
			OFS_LOW_HI:
				low_w_d = {wbyte[BIT_TOP], low_w_q[7:0]};
			OFS_HIGH_LO:
				high_w_d = {high_w_q[8], wbyte};
			OFS_HIGH_HI:
			begin
				high_w_d = {wbyte[BIT_TOP], high_w_q[7:0]};
				inhibit_d = wbyte[BIT_INHIBIT];
			end
			default:
				preset_low_d = preset_low_q;
			endcase
		end
	end

	// count-down timer; every upper write reloads, so a 1-0-1 on the run
	// bit (always made of upper writes) restarts from the preset
	always_comb
	begin
		top_bit_d = top_bit_q;
		run_en_d = run_en_q;
		end_flag_d = end_flag_q;
		cnt_d = cnt_q;
		presc_d = presc_q;
		if (wr_hi)
		begin
			top_bit_d = wbyte[BIT_TOP];
			run_en_d = wbyte[BIT_RUN];
			cnt_d = {wbyte[BIT_TOP], preset_low_q};
			end_flag_d = 1'b0;
			presc_d = 6'h00;
		end
		else if (running)
		begin
			presc_d = presc_q + 6'h01;
			if (tick)
			begin
				if (cnt_q == 9'h000)
					end_flag_d = 1'b1;
				else
					cnt_d = cnt_q - 9'h001;
			end
		end
	end

	// with no carrier the pin is the timer gate itself; with carrier the
	// generator output, which already carries the high-phase tail
	always_comb
	begin
		if (inhibit_q)
			pin_d = running;
		else
			pin_d = car_level;
	end

	rct_carrier u_carrier (
		.mclk(mclk),
		.srst(srst),
		.active(running & ~inhibit_q),
		.low_width(low_w_q),
		.high_width(high_w_q),
		.level(car_level)
	);

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			preset_low_q <= RST_BYTE;
			top_bit_q <= RST_BIT;
			run_en_q <= RST_BIT;
			end_flag_q <= RST_END;
			cnt_q <= RST_WIDTH;
			presc_q <= 6'h00;
			low_w_q <= RST_WIDTH;
			high_w_q <= RST_WIDTH;
			inhibit_q <= RST_INHIBIT;
			pin_q <= RST_BIT;
			prdata_q <= RST_WORD;
			pready_q <= RST_BIT;
			pslverr_q <= RST_BIT;
		end
		else
		begin
			preset_low_q <= preset_low_d;
			top_bit_q <= top_bit_d;
			run_en_q <= run_en_d;
			end_flag_q <= end_flag_d;
			cnt_q <= cnt_d;
			presc_q <= presc_d;
			low_w_q <= low_w_d;
			high_w_q <= high_w_d;
			inhibit_q <= inhibit_d;
			pin_q <= pin_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	property p_load;
		@(posedge mclk) disable iff (srst)
		wr_hi |=> cnt_q == {$past(wbyte[BIT_TOP]), $past(preset_low_q)};
	endproperty
	a_load: assert property (p_load) else $error("counter not loaded from preset");

	property p_low_hold;
		@(posedge mclk) disable iff (srst)
		wr_en && paddr == OFS_PRESET_LO && !tick |=> cnt_q == $past(cnt_q);
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("low preset write touched counter");

	property p_end_clear;
		@(posedge mclk) disable iff (srst)
		wr_hi |=> !end_flag_q;
	endproperty
	a_end_clear: assert property (p_end_clear) else $error("end flag not cleared on load");

	property p_end_sticky;
		@(posedge mclk) disable iff (srst)
		end_flag_q && !wr_hi |=> end_flag_q && cnt_q == $past(cnt_q);
	endproperty
	a_end_sticky: assert property (p_end_sticky) else $error("end state not held");

	property p_stop_zero;
		@(posedge mclk) disable iff (srst)
		tick && cnt_q == 9'h000 && !wr_hi |=> end_flag_q && !running;
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("timer did not end at zero");

	property p_disable;
		@(posedge mclk) disable iff (srst)
		wr_hi && !wbyte[BIT_RUN] |=> !running ##1 !running;
	endproperty
	a_disable: assert property (p_disable) else $error("clearing run did not stop timer");

	property p_step;
		@(posedge mclk) disable iff (srst)
		tick && cnt_q != 9'h000 && !wr_hi |=> cnt_q == $past(cnt_q) - 9'h001 && presc_q == 6'h00;
	endproperty
	a_step: assert property (p_step) else $error("counter step wrong");

	property p_presc_restart;
		@(posedge mclk) disable iff (srst)
		wr_hi |=> presc_q == 6'h00 ##1 presc_q == 6'h00 || running;
	endproperty
	a_presc_restart: assert property (p_presc_restart) else $error("prescaler not restarted");

	property p_reset_low;
		@(posedge mclk) disable iff (srst)
		$past(srst) |-> !remote_output_pin && end_flag_q && inhibit_q;
	endproperty
	a_reset_low: assert property (p_reset_low) else $error("pin or flags wrong after reset");

	property p_end_low;
		@(posedge mclk) disable iff (srst)
		end_flag_q && !car_level |=> !remote_output_pin;
	endproperty
	a_end_low: assert property (p_end_low) else $error("pin not low while ended");

	property p_no_carrier_high;
		@(posedge mclk) disable iff (srst)
		inhibit_q && running |=> remote_output_pin;
	endproperty
	a_no_carrier_high: assert property (p_no_carrier_high) else $error("pin not high without carrier");

	property p_run_bit;
		@(posedge mclk) disable iff (srst)
		wr_hi |=> run_en_q == $past(wbyte[BIT_RUN]);
	endproperty
	a_run_bit: assert property (p_run_bit) else $error("run bit not taken from upper write");

	// read data never carries anything above the byte lane
	property p_rd_zero;
		@(posedge mclk) disable iff (srst)
		pready |-> prdata[31:8] == 24'h00_0000;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("unused read bits not zero");

	property p_low_fixed;
		@(posedge mclk) disable iff (srst)
		setup && !pwrite && paddr == OFS_LOW_HI |=> prdata[7:1] == 7'h00;
	endproperty
	a_low_fixed: assert property (p_low_fixed) else $error("low width fixed bit not zero");

	property p_inhibit_write;
		@(posedge mclk) disable iff (srst)
		wr_en && paddr == OFS_HIGH_HI |=> inhibit_q == $past(wbyte[BIT_INHIBIT]);
	endproperty
	a_inhibit_write: assert property (p_inhibit_write) else $error("carrier inhibit not written");

	property p_inhibit_off_low;
		@(posedge mclk) disable iff (srst)
		inhibit_q && !run_en_q |=> !remote_output_pin;
	endproperty
	a_inhibit_off_low: assert property (p_inhibit_off_low) else $error("pin not low with run off");

	property p_car_gate;
		@(posedge mclk) disable iff (srst)
		!inhibit_q |=> remote_output_pin == $past(car_level);
	endproperty
	a_car_gate: assert property (p_car_gate) else $error("pin does not follow carrier");

	// one prescaler step per clock while the timer runs
	property p_presc_count;
		@(posedge mclk) disable iff (srst)
		running && !wr_hi |=> presc_q == $past(presc_q) + 6'h01;
	endproperty
	a_presc_count: assert property (p_presc_count) else $error("prescaler did not advance");

	property p_idle_hold;
		@(posedge mclk) disable iff (srst)
		!running && !wr_hi |=> cnt_q == $past(cnt_q) && presc_q == $past(presc_q);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("stopped timer still moving");

	// a zero preset still gives one full step before the end flag
	property p_zero_step;
		@(posedge mclk) disable iff (srst)
		wr_hi && wbyte[BIT_RUN] && !wbyte[BIT_TOP] && preset_low_q == 8'h00 |-> ##64 !end_flag_q ##1 end_flag_q;
	endproperty
	a_zero_step: assert property (p_zero_step) else $error("zero preset step length wrong");
endmodule
